/* core/touch_pkg.sv */
package touch_pkg;

   // ---------------------------------------------------------------
   // Command byte layout
   // ---------------------------------------------------------------
   localparam int START_BIT = 7;
   localparam int CHAN_HI   = 6;
   localparam int CHAN_LO   = 4;
   localparam int MODE_BIT  = 3;
   localparam int REF_BIT   = 2;
   localparam int PD_HI     = 1;
   localparam int PD_LO     = 0;

   localparam logic [1:0] PD_AUTO = 2'h0;

   // Arbitrary default: one bit per channel code that drives the panel.
   localparam logic [7:0] POSITION_MASK_DEFAULT = 8'h3A;

   // ---------------------------------------------------------------
   // Serial sequencing counts
   // ---------------------------------------------------------------
   localparam logic [3:0] ENOUGH_BITS   = 4'h5;
   localparam logic [3:0] BYTE_BITS     = 4'h8;
   localparam logic [4:0] FRAME_CLOCKS  = 5'h18;
   localparam logic [4:0] FIRST_SAMPLE  = 5'h0A;
   localparam logic [4:0] RES_FULL      = 5'h0C;
   localparam logic [4:0] RES_SHORT     = 5'h08;
   localparam logic [4:0] SPACING_FULL  = 5'h0F;
   localparam logic [4:0] SPACING_SHORT = 5'h0B;
   localparam logic [4:0] SINCE_MAX     = 5'h1F;
   localparam logic [1:0] BUSY_SINGLE   = 2'h1;
   localparam logic [1:0] BUSY_RATIO    = 2'h2;

   // ---------------------------------------------------------------
   // Host register map and timing
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_COMMAND = 8'h00;
   localparam logic [7:0] REG_STATUS  = 8'h04;
   localparam logic [7:0] REG_RESULT  = 8'h08;
   localparam int STAT_BUSY      = 0;
   localparam int STAT_DONE      = 1;
   localparam int STAT_LINK_BUSY = 2;

   localparam int CLK_PERIOD_NS = 20;
   localparam int SCLK_HALF_NS  = 80;
   localparam int REF_SETTLE_NS = 20000;
   localparam logic [7:0]  SCLK_HALF_CYC  = 8'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] REF_SETTLE_CYC = 16'((REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   function automatic logic is_position(input logic [7:0] mask, input logic [2:0] chan);
      return mask[chan];
   endfunction

   function automatic logic [4:0] res_bits(input logic short_mode);
      return short_mode ? RES_SHORT : RES_FULL;
   endfunction

endpackage

/* core/touch_link_if.sv */
`timescale 1ns/100ps
interface touch_link_if;
   logic cs_n;
   logic serial_clock_in;
   logic serial_data_in;
   logic serial_data_out;
   logic serial_data_out_oe;
   logic busy;
   logic busy_oe;
   logic touch_interrupt_n;
   logic data_out_line;
   logic busy_line;

   // Released lines read as a weak pull: data high, busy low.
   assign data_out_line = serial_data_out_oe ? serial_data_out : 1'h1;
   assign busy_line     = busy_oe ? busy : 1'h0;

   modport device (
      input  cs_n, serial_clock_in, serial_data_in,
      output serial_data_out, serial_data_out_oe, busy, busy_oe, touch_interrupt_n
   );
   modport host (
      output cs_n, serial_clock_in, serial_data_in,
      input  data_out_line, busy_line, touch_interrupt_n
   );
endinterface

/* core/link_sync.sv */
`timescale 1ns/100ps
module link_sync
   import touch_pkg::*;
#(
   parameter int             W   = 1,
   parameter logic [W-1:0]   RST = '0
) (
   input  wire logic         i_clk,
   input  wire logic         i_arst_n,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q,
   output logic              o_rise,
   output logic              o_fall
);
   logic [W-1:0] meta;
   logic         last;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta <= RST;
         o_q  <= RST;
         last <= RST[0];
      end else begin
         meta <= i_d;
         o_q  <= meta;
         last <= o_q[0];
      end
   end

   assign o_rise = o_q[0] & ~last;
   assign o_fall = ~o_q[0] & last;
endmodule

/* core/touch_adc_device.sv */
// Notes on behaviour
// R1: Transfers are eight clocks, conversion 24.
// R2: Host sends command byte in first eight clocks.
// R3: Enough bits received: sample, drive panel.
// R4: Byte complete: hold, single-ended drivers off.
// R5: Conversion spans twelve following clocks.
// R6: Ratiometric keeps drivers on, extra clock.
// R7: Trailing clocks ignored, output held low.
// R8: Input ignored until high start bit.
// R9: Byte: start, channel, mode, reference, power.
// R10: Mode bit picks twelve or eight bits.
// R11: Reference select: external pin or ratiometric.
// R12: New byte every 15th/11th clock.
// R13: Ratiometric only for X, Y, pressure.
// R14: Power code sets reference, converter, interrupt.
// R15: Code zero: low power, Y-minus on.
// R16: Reference power latched when busy rises.
// R17: Converter needs no wake-up; reference settles.
// R18: Sampling lasts three serial clocks.
// R19: Code zero re-enables interrupt at conversion end.
// R20: Interrupt forced low or high during measurement.
// R21: Result MSB first, changed on falling edge.
// R22: Chip select frames; outputs released when high.
//
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/100ps
module touch_adc_device
   import touch_pkg::*;
#(
   parameter logic [7:0] POSITION_MASK = POSITION_MASK_DEFAULT
) (
   input  wire logic        i_clk,
   input  wire logic        i_arst_n,
   touch_link_if.device     link,
   input  wire logic [11:0] i_result,
   input  wire logic        i_pen_touched,
   output logic             o_sample,
   output logic             o_hold,
   output logic             o_drivers_on,
   output logic [2:0]       o_channel,
   output logic             o_ref_external,
   output logic             o_ref_on,
   output logic             o_adc_on,
   output logic             o_ymin_switch,
   output logic             o_short_mode,
   output logic             o_conv_done
);

   // ---------------------------------------------------------------
   // Pin synchronisation
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      D_IDLE = 2'b00,
      D_RECV = 2'b01,
      D_ACQ  = 2'b10
   } dev_state_t;

   logic [2:0] pins;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       cs_n_s;
   logic       din_s;
   logic       rise;
   logic       fall;

   link_sync #(.W(3), .RST(3'h2)) u_sync (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_d      ({link.serial_data_in, link.cs_n, link.serial_clock_in}),
      .o_q      (pins),
      .o_rise   (sclk_rise),
      .o_fall   (sclk_fall)
   );

   assign cs_n_s = pins[1];
   assign din_s  = pins[2];
   // R22: clock ignored outside the frame.
   assign rise   = sclk_rise & ~cs_n_s;
   assign fall   = sclk_fall & ~cs_n_s;

   // ---------------------------------------------------------------
   // Sequencer state
   // ---------------------------------------------------------------
   dev_state_t  state,     next_state;
   logic [3:0]  bit_cnt,   next_bit_cnt;
   logic [7:0]  cmd_sh,    next_cmd_sh;
   logic [4:0]  since,     next_since;
   logic [2:0]  acq_chan,  next_acq_chan;
   logic [2:0]  cfg_chan,  next_cfg_chan;
   logic        cfg_short, next_cfg_short;
   logic        cfg_single, next_cfg_single;
   logic [1:0]  cfg_pd,    next_cfg_pd;
   logic        ref_on,    next_ref_on;
   logic        pen_en,    next_pen_en;
   logic        busy,      next_busy;
   logic [1:0]  busy_left, next_busy_left;
   logic [11:0] out_sh,    next_out_sh;
   logic [4:0]  out_left,  next_out_left;
   logic        dout,      next_dout;
   logic        out_oe,    next_out_oe;
   logic        irq_n,     next_irq_n;
   logic        done,      next_done;
   logic        active;
   logic        acq;
   logic        start_ok;

   assign acq    = (state == D_ACQ);
   assign active = (busy_left != 2'h0) || (out_left != 5'h00);

   // R12: overlapped start allowed at the documented spacing.
   assign start_ok = !active || (since >= (cfg_short ? SPACING_SHORT : SPACING_FULL));

   always_comb begin
      next_state      = state;
      next_bit_cnt    = bit_cnt;
      next_cmd_sh     = cmd_sh;
      next_since      = since;
      next_acq_chan   = acq_chan;
      next_cfg_chan   = cfg_chan;
      next_cfg_short  = cfg_short;
      next_cfg_single = cfg_single;
      next_cfg_pd     = cfg_pd;
      next_ref_on     = ref_on;
      next_pen_en     = pen_en;
      next_busy       = busy;
      next_busy_left  = busy_left;
      next_out_sh     = out_sh;
      next_out_left   = out_left;
      next_dout       = dout;
      next_done       = 1'h0;
      // R22: outputs enabled only while selected.
      next_out_oe     = ~cs_n_s;

      if (rise && since != SINCE_MAX) begin
         next_since = since + 5'h01;
      end

      // R21: result shifted MSB first on falling edges.
      if (fall && busy_left != 2'h0) begin
         next_busy_left = busy_left - 2'h1;
         if (busy_left == 2'h1) begin
            next_busy     = 1'h0;
            next_dout     = out_sh[11];
            next_out_sh   = {out_sh[10:0], 1'h0};
            next_out_left = out_left - 5'h01;
         end
      end else if (fall && out_left != 5'h00) begin
         next_dout     = out_sh[11];
         next_out_sh   = {out_sh[10:0], 1'h0};
         next_out_left = out_left - 5'h01;
         if (out_left == 5'h01) begin
            next_done = 1'h1;
            // R19: interrupt back on at conversion end.
            next_pen_en = (cfg_pd[PD_LO] == 1'h0);
         end
      end else if (fall) begin
         // R7: trailing clocks give low output.
         next_dout = 1'h0;
      end

      case (state)
         D_IDLE: begin
            // R8: wait for a high start bit.
            if (rise && din_s && start_ok) begin
               next_state   = D_RECV;
               next_cmd_sh  = 8'h01;
               next_bit_cnt = 4'h1;
               next_since   = 5'h01;
            end
         end
         D_RECV, D_ACQ: begin
            if (rise && bit_cnt != BYTE_BITS) begin
               next_cmd_sh  = {cmd_sh[6:0], din_s};
               next_bit_cnt = bit_cnt + 4'h1;
               // R3: enter sampling once channel is known.
               if (bit_cnt + 4'h1 == ENOUGH_BITS) begin
                  next_state    = D_ACQ;
                  next_acq_chan = next_cmd_sh[3:1];
               end
            end
            // R4: byte complete, hold and start conversion.
            if (fall && bit_cnt == BYTE_BITS) begin
               // R9: decode command fields.
               next_cfg_chan   = cmd_sh[CHAN_HI:CHAN_LO];
               // R10: resolution for this conversion only.
               next_cfg_short  = cmd_sh[MODE_BIT];
               // R11: reference source select.
               next_cfg_single = cmd_sh[REF_BIT];
               // R14: power code takes effect.
               next_cfg_pd     = cmd_sh[PD_HI:PD_LO];
               // R16: reference state latched with busy.
               next_ref_on     = cmd_sh[PD_HI];
               next_pen_en     = 1'h0;
               next_busy       = 1'h1;
               // R6: ratiometric adds one clock.
               next_busy_left  = cmd_sh[REF_BIT] ? BUSY_SINGLE : BUSY_RATIO;
               next_out_sh     = i_result;
               // R5: twelve or eight result clocks.
               next_out_left   = res_bits(cmd_sh[MODE_BIT]);
               next_dout       = 1'h0;
               next_state      = D_IDLE;
            end
         end
         default: begin
            next_state = D_IDLE;
         end
      endcase

      // R22: deselect aborts the transaction.
      if (cs_n_s) begin
         next_state     = D_IDLE;
         next_busy      = 1'h0;
         next_busy_left = 2'h0;
         next_out_left  = 5'h00;
         next_dout      = 1'h0;
      end

      // R20: interrupt forced during measurement.
      if (next_state == D_ACQ) begin
         next_irq_n = ~is_position(POSITION_MASK, next_acq_chan);
      end else if (next_busy_left != 2'h0 || next_out_left != 5'h00) begin
         next_irq_n = ~is_position(POSITION_MASK, next_cfg_chan);
      end else begin
         next_irq_n = ~(next_pen_en & i_pen_touched);
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state      <= D_IDLE;
         bit_cnt    <= 4'h0;
         cmd_sh     <= 8'h00;
         since      <= SINCE_MAX;
         acq_chan   <= 3'h0;
         cfg_chan   <= 3'h0;
         cfg_short  <= 1'h0;
         cfg_single <= 1'h1;
         cfg_pd     <= PD_AUTO;
         ref_on     <= 1'h0;
         pen_en     <= 1'h1;
         busy       <= 1'h0;
         busy_left  <= 2'h0;
         out_sh     <= 12'h000;
         out_left   <= 5'h00;
         dout       <= 1'h0;
         out_oe     <= 1'h0;
         irq_n      <= 1'h1;
         done       <= 1'h0;
      end else begin
         state      <= next_state;
         bit_cnt    <= next_bit_cnt;
         cmd_sh     <= next_cmd_sh;
         since      <= next_since;
         acq_chan   <= next_acq_chan;
         cfg_chan   <= next_cfg_chan;
         cfg_short  <= next_cfg_short;
         cfg_single <= next_cfg_single;
         cfg_pd     <= next_cfg_pd;
         ref_on     <= next_ref_on;
         pen_en     <= next_pen_en;
         busy       <= next_busy;
         busy_left  <= next_busy_left;
         out_sh     <= next_out_sh;
         out_left   <= next_out_left;
         dout       <= next_dout;
         out_oe     <= next_out_oe;
         irq_n      <= next_irq_n;
         done       <= next_done;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign link.serial_data_out    = dout;
   assign link.serial_data_out_oe = out_oe;
   assign link.busy               = busy;
   assign link.busy_oe            = out_oe;
   assign link.touch_interrupt_n  = irq_n;

   // R18: sampling covers the last three byte clocks.
   assign o_sample       = acq;
   assign o_hold         = active;
   // R4: single-ended drops drivers at hold.
   assign o_drivers_on   = (acq && is_position(POSITION_MASK, acq_chan))
                         || (active && is_position(POSITION_MASK, cfg_chan) && !cfg_single);
   assign o_channel      = acq ? acq_chan : cfg_chan;
   assign o_ref_external = cfg_single;
   assign o_ref_on       = ref_on;
   // R17: converter powers up without delay.
   assign o_adc_on       = acq || active || cfg_pd[PD_LO];
   // R15: low power with Y-minus switch on.
   assign o_ymin_switch  = (cfg_pd == PD_AUTO) && !acq && !active;
   assign o_short_mode   = cfg_short;
   assign o_conv_done    = done;
endmodule

/* core/touch_adc_host.sv */
`timescale 1ns/100ps
module touch_adc_host
   import touch_pkg::*;
#(
   parameter logic [7:0] POSITION_MASK = POSITION_MASK_DEFAULT
) (
   input  wire logic        i_clk,
   input  wire logic        i_arst_n,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   touch_link_if.host       link
);

   // ---------------------------------------------------------------
   // Link sampling and state
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      H_IDLE   = 2'b00,
      H_SETTLE = 2'b01,
      H_FRAME  = 2'b10,
      H_GAP    = 2'b11
   } host_state_t;

   logic [1:0]  pins;
   host_state_t state,      next_state;
   logic [7:0]  cmd,        next_cmd;
   logic [7:0]  tx,         next_tx;
   logic [7:0]  half_cnt,   next_half_cnt;
   logic [15:0] settle_cnt, next_settle_cnt;
   logic        sclk,       next_sclk;
   logic        cs_n,       next_cs_n;
   logic        din,        next_din;
   logic [4:0]  fall_cnt,   next_fall_cnt;
   logic [11:0] result,     next_result;
   logic        done,       next_done;
   logic        ref_was_on, next_ref_was_on;
   logic        ack,        next_ack;
   logic [31:0] rd_dat,     next_rd_dat;
   logic        wb_req;
   logic [7:0]  new_cmd;
   logic [4:0]  first;
   logic [4:0]  f;

   link_sync #(.W(2), .RST(2'h1)) u_sync (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_d      ({link.busy_line, link.data_out_line}),
      .o_q      (pins),
      .o_rise   (),
      .o_fall   ()
   );

   assign wb_req = i_wb_cyc && i_wb_stb && !ack;
   // R13: ratiometric only for panel channels; R8: start bit forced.
   assign new_cmd = {1'h1, i_wb_dat[CHAN_HI:CHAN_LO], i_wb_dat[MODE_BIT],
                     i_wb_dat[REF_BIT] | ~is_position(POSITION_MASK, i_wb_dat[CHAN_HI:CHAN_LO]),
                     i_wb_dat[PD_HI:PD_LO]};
   assign first   = FIRST_SAMPLE + {4'h0, ~cmd[REF_BIT]};
   assign f       = fall_cnt + 5'h01;

   always_comb begin
      next_state      = state;
      next_cmd        = cmd;
      next_tx         = tx;
      next_half_cnt   = half_cnt;
      next_settle_cnt = settle_cnt;
      next_sclk       = sclk;
      next_cs_n       = cs_n;
      next_din        = din;
      next_fall_cnt   = fall_cnt;
      next_result     = result;
      next_done       = done;
      next_ref_was_on = ref_was_on;
      next_ack        = wb_req;
      next_rd_dat     = rd_dat;

      if (wb_req && !i_wb_we) begin
         case (i_wb_adr)
            REG_COMMAND: next_rd_dat = {24'h000000, cmd};
            REG_STATUS:  next_rd_dat = {29'h00000000, pins[1], done, state != H_IDLE};
            REG_RESULT:  next_rd_dat = {20'h00000, result};
            default:     next_rd_dat = 32'h00000000;
         endcase
      end

      case (state)
         H_IDLE: begin
            if (wb_req && i_wb_we && i_wb_sel[0] && i_wb_adr == REG_COMMAND) begin
               next_cmd        = new_cmd;
               next_tx         = new_cmd;
               next_done       = 1'h0;
               next_ref_was_on = new_cmd[PD_HI];
               next_settle_cnt = REF_SETTLE_CYC;
               // R17: let a newly enabled reference settle.
               next_state      = (new_cmd[PD_HI] && !ref_was_on) ? H_SETTLE : H_FRAME;
            end
         end
         H_SETTLE: begin
            next_settle_cnt = settle_cnt - 16'h0001;
            if (settle_cnt == 16'h0001) begin
               next_state = H_FRAME;
            end
         end
         H_FRAME: begin
            // R22: chip select frames the transfer.
            next_cs_n     = 1'h0;
            next_half_cnt = half_cnt + 8'h01;
            if (cs_n) begin
               // R2: command MSB presented before first rise.
               next_din      = tx[START_BIT];
               next_tx       = {tx[6:0], 1'h0};
               next_half_cnt = 8'h00;
               next_fall_cnt = 5'h00;
               next_result   = 12'h000;
            end else if (half_cnt == SCLK_HALF_CYC - 8'h01) begin
               next_half_cnt = 8'h00;
               next_sclk     = ~sclk;
               if (sclk) begin
                  next_fall_cnt = f;
                  next_din      = tx[START_BIT];
                  next_tx       = {tx[6:0], 1'h0};
                  if (f >= first && f < first + res_bits(cmd[MODE_BIT])) begin
                     next_result = {result[10:0], pins[0]};
                  end
                  // R1: three eight-clock transfers per frame.
                  if (f == FRAME_CLOCKS) begin
                     next_cs_n  = 1'h1;
                     next_din   = 1'h0;
                     next_done  = 1'h1;
                     next_state = H_GAP;
                  end
               end
            end
         end
         H_GAP: begin
            next_half_cnt = half_cnt + 8'h01;
            if (half_cnt == SCLK_HALF_CYC - 8'h01) begin
               next_half_cnt = 8'h00;
               next_state    = H_IDLE;
            end
         end
         default: begin
            next_state = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state      <= H_IDLE;
         cmd        <= 8'h00;
         tx         <= 8'h00;
         half_cnt   <= 8'h00;
         settle_cnt <= 16'h0000;
         sclk       <= 1'h0;
         cs_n       <= 1'h1;
         din        <= 1'h0;
         fall_cnt   <= 5'h00;
         result     <= 12'h000;
         done       <= 1'h0;
         ref_was_on <= 1'h0;
         ack        <= 1'h0;
         rd_dat     <= 32'h00000000;
      end else begin
         state      <= next_state;
         cmd        <= next_cmd;
         tx         <= next_tx;
         half_cnt   <= next_half_cnt;
         settle_cnt <= next_settle_cnt;
         sclk       <= next_sclk;
         cs_n       <= next_cs_n;
         din        <= next_din;
         fall_cnt   <= next_fall_cnt;
         result     <= next_result;
         done       <= next_done;
         ref_was_on <= next_ref_was_on;
         ack        <= next_ack;
         rd_dat     <= next_rd_dat;
      end
   end

   assign o_wb_ack             = ack;
   assign o_wb_dat             = rd_dat;
   assign link.cs_n            = cs_n;
   assign link.serial_clock_in = sclk;
   assign link.serial_data_in  = din;
endmodule

/* test/touch_link_monitor.sv */
`timescale 1ns/100ps
module touch_link_monitor
   import touch_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic cs_n,
   input wire logic serial_clock_in,
   input wire logic serial_data_out,
   input wire logic serial_data_out_oe,
   input wire logic busy,
   input wire logic busy_oe,
   input wire logic touch_interrupt_n
);
   logic [4:0] rises;
   logic [4:0] next_rises;
   logic       sclk_q;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   // Counts serial clock rises since chip select fell.
   always_comb next_rises = cs_n ? 5'h00 : rises + {4'h0, serial_clock_in & ~sclk_q};
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rises  <= 5'h00;
         sclk_q <= 1'h0;
      end else begin
         rises  <= next_rises;
         sclk_q <= serial_clock_in;
      end
   end
   AST_BUSY_AT_BYTE: assert property ($rose(busy) |-> $past(rises, 2) == {1'h0, BYTE_BITS})
      else $error("busy rose off the byte end");
   AST_FRAME_LEN: assert property ($rose(cs_n) |-> rises == FRAME_CLOCKS)
      else $error("frame clock count wrong");
   AST_CONV_LEN: assert property ($rose(busy) |-> busy [*6] ##[1:14] !busy)
      else $error("busy length wrong");
   AST_RELEASE: assert property (cs_n [*8] |-> !serial_data_out_oe && !busy_oe)
      else $error("outputs driven while deselected");
   AST_OE_SELECT: assert property (!cs_n [*4] |-> serial_data_out_oe && busy_oe)
      else $error("outputs not driven while selected");
   AST_SCLK_IDLE: assert property (cs_n |-> !serial_clock_in)
      else $error("clock moved while deselected");
   AST_DOUT_ON_FALL: assert property ($changed(serial_data_out) && $past(serial_data_out_oe)
      |-> !$past(serial_clock_in, 2))
      else $error("data changed off a falling clock");
   AST_TRAIL_LOW: assert property ($past(rises, 2) == FRAME_CLOCKS && serial_data_out_oe |-> !serial_data_out)
      else $error("trailing data not low");
   AST_IRQ_STEADY: assert property (busy && $past(busy) |-> $stable(touch_interrupt_n))
      else $error("interrupt moved while busy");
   COV_RATIO: cover property ($rose(busy) ##[12:20] $fell(busy));
   COV_FRAME: cover property ($rose(cs_n));
   COV_IRQ: cover property ($fell(touch_interrupt_n));
endmodule

/* test/tb_touch_adc_serial_control.sv */
`timescale 1ns/100ps
module tb_touch_adc_serial_control
   import touch_pkg::*;
;
   logic        i_clk = 1'h0;
   logic        i_arst_n = 1'h0;
   logic        cyc = 1'h0;
   logic        stb = 1'h0;
   logic        we = 1'h0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic        ack;
   logic        pen = 1'h0;
   logic        short_mode, ref_external, ref_on, adc_on;
   logic [2:0]  chan;
   logic        ymin;
   int          mismatches = 0;
   int          compares = 0;
   int          cycles = 0;
   touch_link_if link ();
   always #10 i_clk = ~i_clk;
   touch_adc_device touch_adc_device_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .link(link),
      .i_result(12'hA5C), .i_pen_touched(pen), .o_sample(), .o_hold(), .o_drivers_on(), .o_channel(chan),
      .o_ref_external(ref_external), .o_ref_on(ref_on), .o_adc_on(adc_on), .o_ymin_switch(ymin),
      .o_short_mode(short_mode), .o_conv_done());
   touch_adc_host touch_adc_host_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .link(link));
   touch_link_monitor touch_link_monitor_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .cs_n(link.cs_n),
      .serial_clock_in(link.serial_clock_in), .serial_data_out(link.serial_data_out),
      .serial_data_out_oe(link.serial_data_out_oe), .busy(link.busy), .busy_oe(link.busy_oe),
      .touch_interrupt_n(link.touch_interrupt_n));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         mismatches++;
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge i_clk);
      cyc  <= 1'h1;
      stb  <= 1'h1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      // Request stands until the rising edge that sees ack high.
      do begin
         @(posedge i_clk);
      end while (ack !== 1'h1);
      q = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
   endtask
   task automatic frame(input logic [7:0] cmd, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'h1, REG_COMMAND, {24'h0, cmd}, q);
      do begin
         bus(1'h0, REG_STATUS, 32'h0, q);
      end while (q[STAT_DONE] !== 1'h1);
      bus(1'h0, REG_RESULT, 32'h0, q);
      chk(q, exp);
   endtask
   task automatic t_codes();
      logic [7:0] cmds [5] = '{8'h93, 8'hDB, 8'hA6, 8'hED, 8'hC4};
      for (int i = 0; i < 5; i++) begin
         frame(cmds[i], cmds[i][3] ? 32'hA5 : 32'hA5C);
         chk(short_mode, cmds[i][3]);
         chk(ref_external, cmds[i][2]);
         chk(ref_on, cmds[i][1]);
         chk(adc_on, cmds[i][0]);
         chk(chan, cmds[i][6:4]);
         chk(ymin, cmds[i][1:0] == PD_AUTO);
         if (!cmds[i][0]) chk(link.touch_interrupt_n, 1'h0);
      end
      $display("codes test done");
   endtask
   task automatic t_refused();
      logic [31:0] q;
      bus(1'h1, REG_COMMAND, 32'hDB, q);
      bus(1'h1, REG_COMMAND, 32'h93, q);
      bus(1'h0, REG_STATUS, 32'h0, q);
      chk(q[STAT_BUSY], 1'h1);
      frame(8'h00, 32'hA5);
      bus(1'h1, 8'h0C, 32'hFFFF, q);
      bus(1'h0, 8'h0C, 32'h0, q);
      chk(q, 32'h0);
      $display("refusal test done");
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 30000) begin
         mismatches++;
         wrap_up();
      end
   end
   initial begin
      repeat (4) @(posedge i_clk);
      i_arst_n <= 1'h1;
      @(negedge i_clk);
      chk(ref_on, 1'h0);
      chk(link.touch_interrupt_n, 1'h1);
      @(posedge i_clk);
      pen <= 1'h1;
      t_codes();
      t_refused();
      wrap_up();
   end
endmodule
